// ### design/sss_pkg.sv
// Shared constants for the soft switch scheduler.
// Assumes a 125 MHz core clock; block writes arrive already decoded.
package sss_pkg;
    // Core clock period in picoseconds
    localparam int unsigned CLK_PERIOD_PS  = 8000;
    // Transition timing in microseconds, as specified
    localparam int unsigned PRE_WAIT_US    = 2300;
    localparam int unsigned SHIFT_PHASE_US = 11200;
    // Cycle counts derived from the times (both divide exactly, no rounding)
    localparam int unsigned PRE_WAIT_CYC   =
        (PRE_WAIT_US * 1000) / (CLK_PERIOD_PS / 1000);
    localparam int unsigned SHIFT_CYC      =
        (SHIFT_PHASE_US * 1000) / (CLK_PERIOD_PS / 1000);
    // Block indices
    localparam int unsigned NUM_BLOCKS     = 7;
    localparam int unsigned NUM_GROUPS     = 4;
    localparam int unsigned BLK_FRONT_LEFT = 0;
    localparam int unsigned BLK_FRONT_RGT  = 1;
    localparam int unsigned BLK_REAR_LEFT  = 2;
    localparam int unsigned BLK_REAR_RGT   = 3;
    localparam int unsigned BLK_CENTER     = 4;
    localparam int unsigned BLK_SUB        = 5;
    localparam int unsigned BLK_MIX        = 6;
    // Select byte and data values of the front mixing switch
    localparam logic [7:0]  MIX_SELECT     = 8'h30;
    localparam logic [7:0]  MIX_ON_VAL     = 8'h80;
    localparam logic [7:0]  MIX_OFF_VAL    = 8'h00;
    // Reset setting of every block (0 dB / mixing off)
    localparam logic [7:0]  GAIN_RESET     = 8'h80;
    localparam logic [7:0]  MIX_RESET      = 8'h00;
    // Default group of each block, 2 bits per block, block 0 lowest
    localparam logic [13:0] GROUP_MAP_DEF  = 14'h0a50;
    // Default group priority, 2 bits each, highest priority first
    localparam logic [7:0]  GROUP_PRIO_DEF = 8'h1b;
    // Transition phases
    typedef enum logic [1:0] {
        SSS_IDLE,
        SSS_WAIT,
        SSS_TO_TEMP,
        SSS_TO_STOP
    } sss_phase_t;
endpackage

// ### design/sss_scheduler.sv
// Soft switch scheduler: groups pending gain blocks and runs one
// pop-free transition at a time, in fixed group priority order.
// Assumes writes are decoded from the serial port on the same clock.
// Assumes the host needs no back-pressure: no write is ever refused.
// One transition runs at a time; all other work waits in the slots.
// Timing counts are parameters so a bench can shrink them.
`timescale 1ns/100ps
module sss_scheduler
    import sss_pkg::*;
#(
    parameter int unsigned          WAIT_CYC   = PRE_WAIT_CYC,
    parameter int unsigned          SHIFT_LEN  = SHIFT_CYC,
    parameter logic [13:0]          GROUP_MAP  = GROUP_MAP_DEF,
    parameter logic [7:0]           GROUP_PRIO = GROUP_PRIO_DEF
) (
    input  wire logic                  clk_i,
    input  wire logic                  rst_n_i,
    input  wire logic                  wr_i,
    input  wire logic [7:0]            wr_select_i,
    input  wire logic [7:0]            wr_data_i,
    output logic                       busy_o,
    output logic [1:0]                 phase_o,
    output logic [1:0]                 active_group_o,
    output logic [NUM_BLOCKS-1:0]      active_blocks_o,
    output logic                       temp_stage_o,
    output logic [NUM_BLOCKS*8-1:0]    applied_o,
    output logic                       mix_on_o
);
    // Gain select bytes of each fader block; mixing last
    // Fader selects run upwards from this byte in block order
    localparam logic [7:0] SEL_BASE = 8'h28;

    // Sequencer state, running transition and per-block vectors
    sss_phase_t            phase_q;
    logic [22:0]           cnt_q; // Holds a full shift phase at 125 MHz
    logic [1:0]            grp_q;
    logic [NUM_BLOCKS-1:0] act_q;
    logic [NUM_BLOCKS-1:0] wr_vec;
    logic [NUM_BLOCKS-1:0] take_vec;
    logic [NUM_BLOCKS-1:0] pend_vec;
    logic [NUM_GROUPS-1:0] grp_pend;
    logic                  found;
    logic [1:0]            next_grp;
    logic [7:0]            wdata;
    logic [NUM_BLOCKS*8-1:0] pend_vals;

    // Write decode: faders at consecutive selects, mixing at its own
    // Other selects are ignored; any block may be written in any cycle
    // So a burst needs no gap between its bytes
    always_comb begin
        wr_vec = '0;
        wdata  = wr_data_i;
        for (int b = 0; b < NUM_BLOCKS - 1; b++) begin
            if (wr_i && wr_select_i == SEL_BASE + 8'(b)) begin
                wr_vec[b] = 1'b1;
            end
        end
        if (wr_i && wr_select_i == MIX_SELECT) begin
            wr_vec[BLK_MIX] = 1'b1;
            // Only bit 7 carries the mixing state
            wdata = wr_data_i[7] ? MIX_ON_VAL : MIX_OFF_VAL;
        end
    end

    // One slot per block keeps latest pending and applied values
    // The take strobe doubles as the apply strobe: a new value shows
    // on applied_o when its transition starts, not when it is written
    for (genvar g = 0; g < NUM_BLOCKS; g++) begin : g_slot
        sss_slot #(
            .RESET_VAL ((g == BLK_MIX) ? MIX_RESET : GAIN_RESET)
        ) u_slot (
            .clk_i      (clk_i),
            .rst_n_i    (rst_n_i),
            .wr_i       (wr_vec[g]),
            .wr_data_i  (wdata),
            .take_i     (take_vec[g]),
            .pending_o  (pend_vec[g]),
            .pend_val_o (pend_vals[g*8 +: 8]),
            .applied_o  (applied_o[g*8 +: 8])
        );
    end

    // Pending flags gathered per group through the mapping
    // A map may use all four groups; an empty group never wins a scan
    always_comb begin
        grp_pend = '0;
        for (int b = 0; b < NUM_BLOCKS; b++) begin
            if (pend_vec[b]) begin
                grp_pend[GROUP_MAP[b*2 +: 2]] = 1'b1;
            end
        end
    end

    // Priority scan; arrival order plays no part in the choice
    // Fields are scanned from the low end up and the last match wins,
    // so the most significant field, written first, ranks highest
    always_comb begin
        found    = 1'b0;
        next_grp = '0;
        for (int p = 0; p < NUM_GROUPS; p++) begin
            if (grp_pend[GROUP_PRIO[p*2 +: 2]]) begin
                found    = 1'b1;
                next_grp = GROUP_PRIO[p*2 +: 2];
            end
        end
    end

    // Start point: idle with something pending, or end of a stop phase
    // A write landing in the last stop cycle is seen only after the
    // return to idle, so that transition pays the full wait again
    logic start_now;
    logic stop_done;
    assign stop_done = (phase_q == SSS_TO_STOP) && (cnt_q == 23'd0);
    assign start_now = found && ((phase_q == SSS_IDLE) || stop_done);

    // Members of the chosen group are latched together at start
    // Blocks of the group that are not pending keep their applied value
    always_comb begin
        take_vec = '0;
        for (int b = 0; b < NUM_BLOCKS; b++) begin
            if (start_now && pend_vec[b] &&
                GROUP_MAP[b*2 +: 2] == next_grp) begin
                take_vec[b] = 1'b1;
            end
        end
    end

    // Phase sequencer; never parks in the temporary stage
    // The counter holds the cycles left in a phase minus one; a phase
    // ends in the cycle in which the counter reads zero
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            phase_q <= SSS_IDLE;
            cnt_q   <= '0;
        end else begin
            unique case (phase_q)
                SSS_IDLE: begin
                    // Wait interval only from rest, before the first shift
                    if (start_now) begin
                        phase_q <= SSS_WAIT;
                        cnt_q   <= 23'(WAIT_CYC - 1);
                    end
                end
                SSS_WAIT: begin
                    if (cnt_q == 23'd0) begin
                        phase_q <= SSS_TO_TEMP;
                        cnt_q   <= 23'(SHIFT_LEN - 1);
                    end else begin
                        cnt_q <= cnt_q - 23'd1;
                    end
                end
                SSS_TO_TEMP: begin
                    if (cnt_q == 23'd0) begin
                        // Temporary stage always hands on to the stop stage
                        phase_q <= SSS_TO_STOP;
                        cnt_q   <= 23'(SHIFT_LEN - 1);
                    end else begin
                        cnt_q <= cnt_q - 23'd1;
                    end
                end
                SSS_TO_STOP: begin
                    if (cnt_q != 23'd0) begin
                        cnt_q <= cnt_q - 23'd1;
                    end else if (start_now) begin
                        // Back-to-back transition skips the wait interval
                        // The output already rests at a stop state then
                        phase_q <= SSS_TO_TEMP;
                        cnt_q   <= 23'(SHIFT_LEN - 1);
                    end else begin
                        phase_q <= SSS_IDLE;
                    end
                end
            endcase
        end
    end

    // Active group held for the whole transition
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            grp_q <= '0;
        end else if (start_now) begin
            grp_q <= next_grp;
        end
    end

    // Member set; cleared on the edge that returns to idle, so the set
    // never outlives its transition
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            act_q <= '0;
        end else if (start_now) begin
            act_q <= take_vec;
        end else if (stop_done || (phase_q == SSS_IDLE)) begin
            act_q <= '0;
        end
    end

    // Status decoded from the phase register; data outputs are all
    // flip-flops, in the slots and in the group and member registers
    assign busy_o          = (phase_q != SSS_IDLE);
    assign phase_o         = phase_q;
    assign active_group_o  = grp_q;
    assign active_blocks_o = act_q;
    assign temp_stage_o    = (phase_q == SSS_TO_TEMP);
    assign mix_on_o        = applied_o[BLK_MIX*8 + 7];
endmodule

// ### design/sss_slot.sv
// One block's setting slot: latest pending value plus applied value.
// Assumes write strobes and load strobes come from the core clock domain.
`timescale 1ns/100ps
module sss_slot
    import sss_pkg::*;
#(
    parameter logic [7:0] RESET_VAL = 8'h80
) (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       wr_i,
    input  wire logic [7:0] wr_data_i,
    input  wire logic       take_i,
    output logic            pending_o,
    output logic [7:0]      pend_val_o,
    output logic [7:0]      applied_o
);
    logic       pend_q;
    logic [7:0] pend_val_q;
    logic [7:0] applied_q;

    // Latest write overwrites older pending value; set beats take
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pend_q     <= 1'b0;
            pend_val_q <= RESET_VAL;
        end else if (wr_i) begin
            pend_val_q <= wr_data_i;
            // Equal to what will be applied: nothing to do
            pend_q     <= (wr_data_i != (take_i ? pend_val_q : applied_q));
        end else if (take_i) begin
            pend_q     <= 1'b0;
        end
    end

    // Applied value moves only when the slot is taken by a transition
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            applied_q <= RESET_VAL;
        end else if (take_i) begin
            applied_q <= pend_val_q;
        end
    end

    assign pending_o  = pend_q;
    assign pend_val_o = pend_val_q;
    assign applied_o  = applied_q;
endmodule

// ### verification/sss_chk.sv
// Port checker for the soft switch scheduler.
// Bound to sss_scheduler from the testbench file; one clock domain.
`timescale 1ns/100ps
module sss_chk
    import sss_pkg::*;
#(
    parameter int unsigned WAIT_CYC  = 5,
    parameter int unsigned SHIFT_LEN = 10
) (
    input wire logic                  clk_i,
    input wire logic                  rst_n_i,
    input wire logic                  wr_i,
    input wire logic [7:0]            wr_select_i,
    input wire logic [7:0]            wr_data_i,
    input wire logic                  busy_o,
    input wire logic [1:0]            phase_o,
    input wire logic [NUM_BLOCKS-1:0] active_blocks_o,
    input wire logic                  temp_stage_o,
    input wire logic [55:0]           applied_o,
    input wire logic                  mix_on_o
);
    logic [1:0]  ph_q;
    logic [31:0] cnt_q;
    logic [31:0] len;
    // Cycles spent in the current phase, this one included
    assign len = (phase_o != ph_q) ? 32'h1 : cnt_q + 32'h1;
    always_ff @(posedge clk_i) begin
        ph_q <= phase_o;
        cnt_q <= len;
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    wait_len_a: assert property (phase_o == 2'h1 && len == WAIT_CYC
        |=> phase_o == 2'h2) else $error("wait phase too long");
    wait_max_a: assert property (phase_o == 2'h1 |-> len <= WAIT_CYC)
        else $error("wait phase overrun");
    shift_len_a: assert property (phase_o == 2'h2 && len == SHIFT_LEN
        |=> phase_o == 2'h3) else $error("shift phase length wrong");
    shift_max_a: assert property (phase_o[1] |-> len <= SHIFT_LEN)
        else $error("shift phase overrun");
    no_halt_a: assert property (phase_o == 2'h2 |=> phase_o[1])
        else $error("stopped in temporary state");
    flags_a: assert property (busy_o == (phase_o != 2'h0)
        && temp_stage_o == (phase_o == 2'h2)) else $error("flag mismatch");
    idle_clear_a: assert property (phase_o == 2'h0 |-> !active_blocks_o)
        else $error("blocks set while idle");
    refresh_a: assert property (wr_i && wr_select_i == 8'h28
        && wr_data_i == applied_o[7:0] && phase_o == 2'h0 && !$past(wr_i)
        |-> ##2 phase_o == 2'h0) else $error("refresh started a switch");
    start_a: assert property (wr_i && wr_select_i == 8'h28
        && wr_data_i != applied_o[7:0] && phase_o == 2'h0 && !$past(wr_i)
        |-> ##2 phase_o == 2'h1 && applied_o[7:0] == $past(wr_data_i, 2))
        else $error("idle write did not start");
    mix_a: assert property (wr_i && wr_select_i == 8'h30 && !$past(wr_i)
        && wr_data_i[7] != mix_on_o && phase_o == 2'h0
        |-> ##2 mix_on_o == $past(wr_data_i[7], 2)) else $error("mix wrong");
    back_c: cover property (phase_o == 2'h3 ##1 phase_o == 2'h2);
    pair_c: cover property (active_blocks_o == 7'h03);
    mixoff_c: cover property ($fell(mix_on_o));
endmodule

// ### verification/sss_host.sv
// Host side model: turns queued setting writes into decoded strobes.
// Drives on the falling clock edge, one write a cycle, back to back.
`timescale 1ns/100ps
module sss_host (
    input  wire logic       clk_i,
    output logic            wr_o,
    output logic [7:0]      sel_o,
    output logic [7:0]      data_o
);
    logic [15:0] q [$];
    // Queue a write; calls in one time step form a burst
    task automatic put(input logic [7:0] s, input logic [7:0] d);
        q.push_back({s, d});
    endtask
    initial begin
        wr_o = 1'b0;
        sel_o = 8'h00;
        data_o = 8'h00;
    end
    // Idle bus inverts its bytes each idle cycle, so every other idle cycle shows the last write again
    always @(negedge clk_i) begin
        if (q.size() > 0) begin
            wr_o <= 1'b1;
            {sel_o, data_o} <= q.pop_front();
        end else begin
            wr_o <= 1'b0;
            sel_o <= ~sel_o;
            data_o <= ~data_o;
        end
    end
endmodule

// ### verification/testbench.sv
// Self-checking bench for the soft switch scheduler.
// Host model supplies writes; short wait and shift counts keep it fast.
`timescale 1ns/100ps
module testbench;
    import sss_pkg::*;
    localparam int unsigned W = 5;
    localparam int unsigned S = 10;
    logic clk_i, rst_n_i, wr_i, busy_o, temp_stage_o, mix_on_o;
    logic [7:0]  sel;
    logic [7:0]  dat;
    logic [1:0]  phase_o;
    logic [1:0]  active_group_o;
    logic [6:0]  active_blocks_o;
    logic [55:0] applied_o;
    int          n_mismatch;
    int          samples_checked;
    sss_host sss_host_inst (.clk_i(clk_i), .wr_o(wr_i), .sel_o(sel),
        .data_o(dat));
    sss_scheduler #(.WAIT_CYC(W), .SHIFT_LEN(S)) sss_scheduler_inst (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .wr_i(wr_i), .wr_select_i(sel),
        .wr_data_i(dat), .busy_o(busy_o), .phase_o(phase_o),
        .active_group_o(active_group_o), .active_blocks_o(active_blocks_o),
        .temp_stage_o(temp_stage_o), .applied_o(applied_o),
        .mix_on_o(mix_on_o));
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    task automatic finish_test();
        $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [55:0] e,
                       input logic [55:0] g);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Bounded wait for a phase, counting wait-phase cycles on the way
    task automatic wait_ph(input logic [1:0] p, output int n1);
        n1 = 0;
        for (int i = 0; i < 400 && phase_o !== p; i++) begin
            if (phase_o === 2'h1) n1++;
            @(negedge clk_i);
        end
        if (phase_o !== p) begin
            chk("timeout", p, phase_o);
            finish_test();
        end
    endtask
    // One whole transition: group, blocks and phase lengths
    task automatic xfer(input logic [1:0] g, input logic [6:0] b,
                        input int w);
        int n1;
        int n;
        wait_ph(2'h2, n1);
        if (w >= 0) chk("wait", w, n1);
        chk("group", g, active_group_o);
        chk("blocks", b, active_blocks_o);
        for (n = 0; phase_o === 2'h2 && n < 400; n++) @(negedge clk_i);
        chk("to temp", S, n);
        for (n = 0; phase_o === 2'h3 && n < 400; n++) @(negedge clk_i);
        chk("to stop", S, n);
    endtask
    task automatic t_order();
        int n1;
        sss_host_inst.put(MIX_SELECT, MIX_ON_VAL);
        wait_ph(2'h1, n1);
        sss_host_inst.put(8'h2c, 8'h9a);
        sss_host_inst.put(8'h2a, 8'h9a);
        sss_host_inst.put(8'h28, 8'h9a);
        sss_host_inst.put(8'h29, 8'h9a);
        xfer(2'h0, 7'h40, -1);
        xfer(2'h0, 7'h03, 0);
        xfer(2'h1, 7'h04, 0);
        xfer(2'h2, 7'h10, 0);
        chk("applied", 56'h80809a809a9a9a, applied_o);
        chk("mix on", 1'b1, mix_on_o);
    endtask
    task automatic t_latest();
        int n1;
        sss_host_inst.put(8'h28, 8'h11);
        wait_ph(2'h2, n1);
        chk("wait", W, n1);
        sss_host_inst.put(8'h2b, 8'h7c);
        sss_host_inst.put(8'h2b, 8'hff);
        sss_host_inst.put(MIX_SELECT, MIX_OFF_VAL);
        wait_ph(2'h3, n1);
        xfer(2'h0, 7'h40, 0);
        xfer(2'h1, 7'h08, 0);
        repeat (W + 2) @(negedge clk_i);
        chk("idle", 1'b0, busy_o);
        chk("rear", 8'hff, applied_o[31:24]);
        chk("mix off", 1'b0, mix_on_o);
        sss_host_inst.put(8'h28, 8'h11);
        repeat (6) @(negedge clk_i);
        chk("refresh", 1'b0, busy_o);
    endtask
    initial begin
        n_mismatch = 0;
        samples_checked = 0;
        rst_n_i = 1'b0;
        repeat (2) @(negedge clk_i);
        rst_n_i = 1'b1;
        @(negedge clk_i);
        chk("reset", 56'h00808080808080, applied_o);
        chk("busy", 1'b0, busy_o);
        t_order();
        t_latest();
        finish_test();
    end
endmodule
bind sss_scheduler sss_chk #(.WAIT_CYC(WAIT_CYC), .SHIFT_LEN(SHIFT_LEN))
    sss_chk_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .wr_i(wr_i),
    .wr_select_i(wr_select_i), .wr_data_i(wr_data_i), .busy_o(busy_o),
    .phase_o(phase_o), .active_blocks_o(active_blocks_o),
    .temp_stage_o(temp_stage_o), .applied_o(applied_o),
    .mix_on_o(mix_on_o));
